// >>> design/csies_consts.vh
// Register offsets, field positions and reset values of the error status capture block.
`ifndef CSIES_CONSTS_VH
`define CSIES_CONSTS_VH
`define CSIES_OFS_GLOBAL_EN    8'h20
`define CSIES_OFS_STATUS       8'h24
`define CSIES_OFS_IRQ_EN       8'h28
`define CSIES_STATUS_RESET     32'h00000000
`define CSIES_IRQ_EN_RESET     32'h00000000
`define CSIES_GLOBAL_EN_RESET  1'h0
`define CSIES_IMPL_MASK        32'h807E3FFF
`define CSIES_BIT_FRAME_RX     31
`define CSIES_BIT_WC_CORRUPT   22
`define CSIES_BIT_LANE_CFG     21
`define CSIES_BIT_SPF_FULL     20
`define CSIES_BIT_SPF_NEMPTY   19
`define CSIES_BIT_LB_FULL      18
`define CSIES_BIT_STOP_STATE   17
`define CSIES_BIT_SOT_BURST    13
`define CSIES_BIT_SOT_SYNC     12
`define CSIES_BIT_ECC_DOUBLE   11
`define CSIES_BIT_ECC_SINGLE   10
`define CSIES_BIT_CRC          9
`define CSIES_BIT_UNKNOWN_DT   8
`define CSIES_BIT_VC_SYNC_BASE 1
`define CSIES_BIT_VC_DATA_BASE 0
`define CSIES_SYNC_LB_FULL     0
`define CSIES_SYNC_SPF_FULL    1
`define CSIES_SYNC_SPF_NEMPTY  2
`define CSIES_SYNC_STOP        3
`define CSIES_SYNC_SOT_BURST   4
`define CSIES_SYNC_SOT_SYNC    5
`define CSIES_SYNC_COUNT       6
`endif

// >>> design/csies_error_status.v
// Error and status capture with write-one-to-clear status and gated interrupt.
`timescale 1ns/1ps
// What this block does
// (R01) Set bit 21 while programmed active lanes exceed maximum lanes.
// (R02) Set bit 20 when short packet FIFO full is seen.
// (R03) Set bit 19 when short packet FIFO holds an entry.
// (R04) Set bit 18 when the stream line buffer is full.
// (R05) Software recovers from line buffer full by the external video reset.
// (R06) Set bit 17 when the lane interface reports Stop state.
// (R07) Set bit 13 on a start-of-transmission burst error.
// (R08) Set bit 12 when start-of-transmission sync fails completely.
// (R09) Set bit 11 on a two-bit header ECC error.
// (R10) Set bit 10 on a corrected single-bit header ECC error.
// (R11) Set bit 9 when payload checksum mismatches.
// (R12) Set bit 8 on an unknown or unimplemented data identifier.
// (R13) Frame end without frame start sets that channel's pairing error bit.
// (R14) Frame end after payload checksum error sets that channel's payload error bit.
// (R15) A sync failure also raises the frame pairing error.
// (R16) Writing one clears a status bit; writing zero keeps it.
// (R17) Cross-domain conditions pass through two-flop synchronisers.
// (R18) A set in the same cycle as a clear leaves the bit set.
// (R19) Double-bit header errors are charged to the header's channel field.
// (R20) Sync failures are charged to the channel last seen by the header stage.
// (R21) Set bit 31 when a frame end short packet is received.
// (R22) Set bit 22 on word count corruption beyond ECC detection.
// (R23) Master enable clear blocks the interrupt entirely.
// (R24) Per-bit enables gate the interrupt only, never the capture.
// (R25) Interrupt is a high level: master enable and any enabled set bit.
`include "csies_consts.vh"

module csies_error_status (
  // Clock and reset; reset_n is the external video reset.
  input  wire        mclk,
  input  wire        reset_n,
  // Register port.
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Lane configuration from the protocol configuration.
  input  wire [1:0]  active_lanes,
  input  wire [1:0]  max_lanes,
  // Core clock domain conditions, asynchronous here.
  input  wire        line_buffer_full,
  input  wire        spkt_fifo_full,
  input  wire        spkt_fifo_not_empty,
  // Lane interface conditions, asynchronous here.
  input  wire        lane_stop_state,
  input  wire        sot_burst_error,
  input  wire        sot_sync_failure,
  // Packet decoder events, one-cycle pulses in this clock domain.
  input  wire        header_valid,
  input  wire [1:0]  header_vc,
  input  wire        header_double_bit_error,
  input  wire        header_single_bit_fixed,
  input  wire        payload_checksum_error,
  input  wire        unknown_data_type_error,
  input  wire        word_count_corrupt,
  input  wire        frame_start,
  input  wire        frame_end,
  // Interrupt output.
  output wire        irq
);

  reg  [31:0]                  status;
  reg  [31:0]                  irq_enable;
  reg                          global_enable;
  reg  [`CSIES_SYNC_COUNT-1:0] sync_meta;
  reg  [`CSIES_SYNC_COUNT-1:0] sync_out;
  reg                          sot_sync_prev;
  reg                          sot_burst_prev;
  reg  [1:0]                   last_vc;
  reg  [3:0]                   in_frame;
  reg  [3:0]                   payload_bad;
  reg  [31:0]                  set_vec;
  reg  [31:0]                  clr_vec;
  reg  [31:0]                  next_status;
  reg  [3:0]                   next_in_frame;
  reg  [3:0]                   next_payload_bad;
  wire                         sot_sync_rise;
  wire                         sot_burst_rise;
  wire [3:0]                   sync_err_vc;
  wire [3:0]                   data_err_vc;

  // Levels from foreign domains: meta stage feeds only the second stage.
  genvar g;
  generate
    for (g = 0; g < `CSIES_SYNC_COUNT; g = g + 1) begin : g_sync
      wire raw_in;
      assign raw_in = (g == `CSIES_SYNC_LB_FULL)    ? line_buffer_full :
                      (g == `CSIES_SYNC_SPF_FULL)   ? spkt_fifo_full :
                      (g == `CSIES_SYNC_SPF_NEMPTY) ? spkt_fifo_not_empty :
                      (g == `CSIES_SYNC_STOP)       ? lane_stop_state :
                      (g == `CSIES_SYNC_SOT_BURST)  ? sot_burst_error :
                                                      sot_sync_failure;
      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          sync_meta[g] <= 1'b0;
          sync_out[g]  <= 1'b0;
        end else begin
          sync_meta[g] <= raw_in; // (R17)
          sync_out[g]  <= sync_meta[g]; // (R17)
        end
      end
    end
  endgenerate

  assign sot_sync_rise  = sync_out[`CSIES_SYNC_SOT_SYNC] & ~sot_sync_prev;
  assign sot_burst_rise = sync_out[`CSIES_SYNC_SOT_BURST] & ~sot_burst_prev;

  // Per-channel frame tracking and error attribution.
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_vc
      wire fe_here;
      wire fs_here;
      assign fe_here = frame_end & (header_vc == g);
      assign fs_here = frame_start & (header_vc == g);
      assign sync_err_vc[g] = (fe_here & ~in_frame[g]) | // (R13)
                              (sot_sync_rise & (last_vc == g)); // (R15) (R20)
      assign data_err_vc[g] = fe_here & payload_bad[g]; // (R14)
      always @* begin
        next_in_frame[g]    = in_frame[g];
        next_payload_bad[g] = payload_bad[g];
        if (fe_here) begin
          next_in_frame[g]    = 1'b0;
          next_payload_bad[g] = 1'b0;
        end else if (fs_here) begin
          next_in_frame[g]    = 1'b1;
          next_payload_bad[g] = 1'b0;
        end else if (((payload_checksum_error | header_double_bit_error) &
                      (header_vc == g)) | // (R14) (R19)
                     (sot_sync_rise & (last_vc == g))) begin // (R20)
          next_payload_bad[g] = 1'b1;
        end
      end
    end
  endgenerate

  always @* begin
    set_vec = 32'h00000000;
    set_vec[`CSIES_BIT_FRAME_RX]   = frame_end; // (R21)
    set_vec[`CSIES_BIT_WC_CORRUPT] = word_count_corrupt; // (R22)
    set_vec[`CSIES_BIT_LANE_CFG]   = (active_lanes > max_lanes); // (R01)
    set_vec[`CSIES_BIT_SPF_FULL]   = sync_out[`CSIES_SYNC_SPF_FULL]; // (R02)
    set_vec[`CSIES_BIT_SPF_NEMPTY] = sync_out[`CSIES_SYNC_SPF_NEMPTY]; // (R03)
    // The line buffer bit stays set while full; only the video reset recovers.
    set_vec[`CSIES_BIT_LB_FULL]    = sync_out[`CSIES_SYNC_LB_FULL]; // (R04) (R05)
    set_vec[`CSIES_BIT_STOP_STATE] = sync_out[`CSIES_SYNC_STOP]; // (R06)
    set_vec[`CSIES_BIT_SOT_BURST]  = sot_burst_rise; // (R07)
    set_vec[`CSIES_BIT_SOT_SYNC]   = sot_sync_rise; // (R08)
    set_vec[`CSIES_BIT_ECC_DOUBLE] = header_double_bit_error; // (R09)
    set_vec[`CSIES_BIT_ECC_SINGLE] = header_single_bit_fixed; // (R10)
    set_vec[`CSIES_BIT_CRC]        = payload_checksum_error; // (R11)
    set_vec[`CSIES_BIT_UNKNOWN_DT] = unknown_data_type_error; // (R12)
    set_vec[`CSIES_BIT_VC_SYNC_BASE+6] = sync_err_vc[3]; // (R13)
    set_vec[`CSIES_BIT_VC_SYNC_BASE+4] = sync_err_vc[2]; // (R13)
    set_vec[`CSIES_BIT_VC_SYNC_BASE+2] = sync_err_vc[1]; // (R13)
    set_vec[`CSIES_BIT_VC_SYNC_BASE]   = sync_err_vc[0]; // (R13)
    set_vec[`CSIES_BIT_VC_DATA_BASE+6] = data_err_vc[3]; // (R14)
    set_vec[`CSIES_BIT_VC_DATA_BASE+4] = data_err_vc[2]; // (R14)
    set_vec[`CSIES_BIT_VC_DATA_BASE+2] = data_err_vc[1]; // (R14)
    set_vec[`CSIES_BIT_VC_DATA_BASE]   = data_err_vc[0]; // (R14)
    clr_vec = 32'h00000000;
    if (reg_wr && (reg_addr == `CSIES_OFS_STATUS)) begin
      clr_vec = reg_wdata; // (R16)
    end
    // Set is applied after the clear so a coincident event survives.
    next_status = ((status & ~clr_vec) | set_vec) & `CSIES_IMPL_MASK; // (R16) (R18)
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status         <= `CSIES_STATUS_RESET;
      irq_enable     <= `CSIES_IRQ_EN_RESET;
      global_enable  <= `CSIES_GLOBAL_EN_RESET;
      sot_sync_prev  <= 1'b0;
      sot_burst_prev <= 1'b0;
      last_vc        <= 2'h0;
      in_frame       <= 4'h0;
      payload_bad    <= 4'h0;
      reg_rdata      <= 32'h00000000;
    end else begin
      status         <= next_status;
      sot_sync_prev  <= sync_out[`CSIES_SYNC_SOT_SYNC];
      sot_burst_prev <= sync_out[`CSIES_SYNC_SOT_BURST];
      in_frame       <= next_in_frame;
      payload_bad    <= next_payload_bad;
      if (header_valid) begin
        last_vc <= header_vc; // (R20)
      end
      if (reg_wr && (reg_addr == `CSIES_OFS_IRQ_EN)) begin
        irq_enable <= reg_wdata & `CSIES_IMPL_MASK;
      end
      if (reg_wr && (reg_addr == `CSIES_OFS_GLOBAL_EN)) begin
        global_enable <= reg_wdata[0];
      end
      if (reg_rd) begin
        case (reg_addr)
          `CSIES_OFS_GLOBAL_EN: reg_rdata <= {31'h00000000, global_enable};
          `CSIES_OFS_STATUS:    reg_rdata <= status;
          `CSIES_OFS_IRQ_EN:    reg_rdata <= irq_enable;
          default:              reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Enables only gate the output; capture above ignores them.
  assign irq = global_enable & (|(status & irq_enable)); // (R23) (R24) (R25)

endmodule // csies_error_status

// >>> sim/csies_error_status_assertions.sv
// Checker of status capture, clearing and interrupt gating at the block's ports.
`timescale 1ns/1ps
module csies_error_status_chk (
  // Clock, reset and register port.
  input wire        mclk,
  input wire        reset_n,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire [31:0] reg_wdata,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  // Event sources and interrupt.
  input wire [1:0]  active_lanes,
  input wire [1:0]  max_lanes,
  input wire        payload_checksum_error,
  input wire        frame_end,
  input wire        irq
);
  wire clr9 = reg_wr && reg_addr == 8'h24 && reg_wdata[9];
  wire clr21 = reg_wr && reg_addr == 8'h24 && reg_wdata[21];
  wire clr31 = reg_wr && reg_addr == 8'h24 && reg_wdata[31];
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_rd; reg_rd && reg_addr == 8'h24; endsequence
  // A read may follow the event directly or after one idle cycle without a clear.
  property p_crc;
    (payload_checksum_error ##1 s_rd) or
    (payload_checksum_error ##1 !clr9 ##1 s_rd) |=> reg_rdata[9];
  endproperty
  a_crc: assert property (p_crc) else $error("bit 9 not set");
  property p_frx;
    (frame_end ##1 s_rd) or (frame_end ##1 !clr31 ##1 s_rd) |=> reg_rdata[31];
  endproperty
  a_frx: assert property (p_frx) else $error("bit 31 not set");
  property p_lane;
    (active_lanes > max_lanes ##1 s_rd) or
    (active_lanes > max_lanes ##1 !clr21 ##1 s_rd) |=> reg_rdata[21];
  endproperty
  a_lane: assert property (p_lane) else $error("bit 21 not set");
  property p_w1c;
    (clr9 && !payload_checksum_error ##1 s_rd) or
    (clr9 && !payload_checksum_error ##1 !payload_checksum_error ##1 s_rd)
      |=> !reg_rdata[9];
  endproperty
  a_w1c: assert property (p_w1c) else $error("bit 9 not cleared");
  property p_win;
    (clr9 && payload_checksum_error ##1 s_rd) or
    (clr9 && payload_checksum_error ##1 !clr9 ##1 s_rd) |=> reg_rdata[9];
  endproperty
  a_win: assert property (p_win) else $error("clear beat set");
  property p_gen; reg_rd && reg_addr == 8'h20 && !reg_wr |=> reg_rdata[0] || !irq; endproperty
  a_gen: assert property (p_gen) else $error("irq without master enable");
  property p_ier; reg_rd && reg_addr == 8'h28 && !reg_wr |=> reg_rdata != 0 || !irq; endproperty
  a_ier: assert property (p_ier) else $error("irq with no enables");
  property p_rst; $rose(reset_n) |-> !irq; endproperty
  a_rst: assert property (p_rst) else $error("irq high out of reset");
  c_irq: cover property (irq);
  c_win: cover property (clr9 && payload_checksum_error);
  c_fe: cover property (frame_end ##[1:2] s_rd);
endmodule // csies_error_status_chk
bind csies_error_status csies_error_status_chk u_chk (.mclk(mclk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .active_lanes(active_lanes), .max_lanes(max_lanes),
  .payload_checksum_error(payload_checksum_error), .frame_end(frame_end), .irq(irq));

// >>> sim/testbench.sv
// Self-checking bench for the error status capture block.
`timescale 1ns/1ps
`include "csies_consts.vh"
module testbench;
  reg          mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, ge = 0;
  reg [7:0]    reg_addr = 0, pul = 0;
  reg [31:0]   reg_wdata = 0, st = 0, per_event_irq_enable = 0;
  reg [5:0]    lvl = 0;
  reg [3:0]    bad = 0, infr = 0;
  reg [1:0]    active_lanes = 0, max_lanes = 0, header_vc = 0, lvc = 0, v;
  wire [31:0]  reg_rdata;
  wire         irq;
  int          n_fail = 0, n_tests = 0, cyc = 0, i;
  int          lb[6] = '{18, 20, 19, 17, 13, 12};
  logic [31:0] q[$];
  always #5 mclk = ~mclk;
  csies_error_status uut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .active_lanes(active_lanes), .max_lanes(max_lanes), .line_buffer_full(lvl[0]),
    .spkt_fifo_full(lvl[1]), .spkt_fifo_not_empty(lvl[2]), .lane_stop_state(lvl[3]),
    .sot_burst_error(lvl[4]), .sot_sync_failure(lvl[5]), .header_valid(pul[7]),
    .header_vc(header_vc), .header_double_bit_error(pul[0]),
    .header_single_bit_fixed(pul[1]), .payload_checksum_error(pul[2]),
    .unknown_data_type_error(pul[3]), .word_count_corrupt(pul[4]),
    .frame_start(pul[5]), .frame_end(pul[6]), .irq(irq));
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Automatic because the reader and the monitor may compare in the same time step.
  task automatic chk(input [31:0] got, input [31:0] e);
    n_tests++;
    if (got !== e) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, e);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1;
    @(negedge mclk) reg_wr = 0;
    if (a == 8'h24) st = st & ~d;
    if (a == 8'h28) per_event_irq_enable = d & `CSIES_IMPL_MASK;
    if (a == 8'h20) ge = d[0];
    // One idle cycle keeps a following call from raising the strobe just lowered.
    @(negedge mclk);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    q.push_back(e); reg_addr = a; reg_rd = 1;
    @(negedge mclk) reg_rd = 0;
    chk({31'h0, irq}, {31'h0, ge && |(st & per_event_irq_enable)});
    @(negedge mclk);
  endtask
  task ev(input [2:0] k, input [1:0] c);
    header_vc = c; pul[k] = 1;
    @(negedge mclk) pul = 0;
    if (k == 0 || k == 2) bad[c] = 1;
    case (k)
      0, 1, 2, 3: st[11 - k] = 1;
      4: st[22] = 1;
      5: begin infr[c] = 1; bad[c] = 0; end
      6: begin st[31] = 1; st[2 * c + 1] |= !infr[c]; st[2 * c] |= bad[c]; infr[c] = 0; bad[c] = 0; end
      7: lvc = c;
    endcase
    @(negedge mclk);
  endtask
  // Levels are held, dropped, then given time to cross the synchronisers.
  task lv(input int k);
    lvl[k] = 1;
    repeat (2) @(negedge mclk);
    lvl[k] = 0;
    repeat (4) @(negedge mclk);
    st[lb[k]] = 1;
    if (k == 5) begin st[2 * lvc + 1] = 1; bad[lvc] = 1; end
    rd(8'h24, st);
  endtask
  always @(posedge mclk) rd_d <= reg_rd;
  always @(negedge mclk) if (rd_d) chk(reg_rdata, q.pop_front());
  always @(posedge mclk) if (++cyc == 2000) begin n_fail++; final_report; end
  initial begin
    void'($urandom(32'h0D18F2D5));
    repeat (6) @(negedge mclk);
    reset_n = 1;
    @(negedge mclk);
    for (i = 0; i < 4; i++) rd(8'h20 + 8'(4 * i), 0);
    wr(8'h28, $urandom);
    rd(8'h28, per_event_irq_enable);
    wr(8'h20, 1);
    rd(8'h20, 1);
    for (i = 0; i < 12; i++) begin
      v = 2'($urandom);
      if (i % 4 != 3) ev(5, v);
      ev(3'(i % 5), v);
      rd(8'h24, st);
      ev(6, v);
      rd(8'h24, st);
    end
    ev(7, 2'h2);
    for (i = 0; i < 6; i++) lv(i);
    ev(6, 2'h2);
    rd(8'h24, st);
    for (i = 0; i < 4; i++) begin
      active_lanes = i ? 2'($urandom) : 2'h3;
      max_lanes = i ? 2'($urandom) : 2'h0;
      @(negedge mclk);
      if (active_lanes > max_lanes) st[21] = 1;
      rd(8'h24, st);
    end
    active_lanes = 0;
    wr(8'h24, 32'hFFFFFFFF);
    rd(8'h24, st);
    pul[2] = 1;
    header_vc = 2'h1;
    wr(8'h24, 32'h200);
    pul = 0;
    st[9] = 1;
    bad[1] = 1;
    rd(8'h24, st);
    wr(8'h28, 0);
    rd(8'h28, 0);
    wr(8'h28, 32'h200);
    rd(8'h24, st);
    wr(8'h20, 0);
    rd(8'h20, 0);
    wr(8'h24, 32'h200);
    rd(8'h24, st);
    ev(3, 2'h0);
    reset_n = 0;
    @(negedge mclk);
    reset_n = 1;
    {st, per_event_irq_enable, ge, bad, infr, lvc} = 0;
    rd(8'h24, 0);
    rd(8'h28, 0);
    @(negedge mclk);
    final_report;
  end
endmodule // testbench
